/* File: core/scc_regs.sv */
// serial register bank and sync, clamp and coast path logic
module scc_regs (
  input  wire logic       CLOCK,
  input  wire logic       RESET_N,
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       HSYNC_IN,
  input  wire logic       SOG_IN,
  input  wire logic       VSYNC_IN,
  input  wire logic       CLAMP_IN,
  input  wire logic       COAST_IN,
  input  wire logic       HSYNC_PRESENT,
  input  wire logic       SOG_PRESENT,
  input  wire logic       VSYNC_PRESENT,
  output logic            PLL_HSYNC,
  output logic            HSYNC_OUT,
  output logic            VSYNC_OUT,
  output logic            CLAMP,
  output logic            COAST_ACTIVE,
  output logic            ACTIVE_HSYNC_SOURCE_STATUS,
  output logic            ACTIVE_VSYNC_SOURCE_STATUS,
  output logic            HSYNC_POL_DETECT,
  output logic            COAST_POL_DETECT,
  output logic            SEEK_ALLOW,
  output logic            FULL_POWER_DOWN_N,
  output logic [4:0]      SOG_LEVEL,
  output logic            RED_CLAMP_MID,
  output logic            BLUE_CLAMP_MID
);
  scc_pkg::scc_sync_ctrl_t sync_ctrl;
  scc_pkg::scc_cc_ctrl_t   cc_ctrl;
  scc_pkg::scc_sog_ctrl_t  sog_ctrl;
  logic [7:0]              sep_thr;
  logic [7:0]              lead_lines;
  logic [7:0]              trail_lines;
  scc_pkg::scc_ser_state_t state;
  logic                    scl_d;
  logic                    sda_d;
  logic [7:0]              shreg;
  logic [7:0]              tx;
  logic [3:0]              bitcnt;
  logic [7:0]              ptr;
  logic                    rw;
  logic                    nack;
  logic                    wr_stb;
  logic [7:0]              wr_data;
  function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                         input logic [7:0] s, input logic [7:0] c,
                                         input logic [7:0] g, input logic [7:0] t,
                                         input logic [7:0] l, input logic [7:0] r);
    case (a)
      scc_pkg::ADDR_SYNC:  rd_byte = s;
      scc_pkg::ADDR_CC:    rd_byte = {c[7:1], 1'b0};
      scc_pkg::ADDR_SOG:   rd_byte = g;
      scc_pkg::ADDR_SEP:   rd_byte = t;
      scc_pkg::ADDR_LEAD:  rd_byte = l;
      scc_pkg::ADDR_TRAIL: rd_byte = r;
      default:             rd_byte = 8'h00;
    endcase
  endfunction : rd_byte
  // serial port: scl and sda are sampled as plain synchronous levels
  wire scl_rise = SCL & ~scl_d;
  wire scl_fall = ~SCL & scl_d;
  wire start_c  = SCL & scl_d & sda_d & ~SDA_IN;
  wire stop_c   = SCL & scl_d & ~sda_d & SDA_IN;
  wire [7:0] rd_now  = rd_byte(ptr, sync_ctrl, cc_ctrl, sog_ctrl, sep_thr, lead_lines, trail_lines);
  wire [7:0] ptr_inc = ptr + 8'h01;
  wire [7:0] rd_inc  = rd_byte(ptr_inc, sync_ctrl, cc_ctrl, sog_ctrl, sep_thr, lead_lines, trail_lines);
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= SCL;
      sda_d <= SDA_IN;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state   <= scc_pkg::ST_IDLE;
      shreg   <= 8'h00;
      tx      <= 8'h00;
      bitcnt  <= 4'h0;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      nack    <= 1'b0;
      wr_stb  <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        state  <= scc_pkg::ST_ADDR;
        bitcnt <= 4'h0;
      end else if (stop_c) begin
        state <= scc_pkg::ST_IDLE;
      end else if (scl_rise) begin
        if (state == scc_pkg::ST_ADDR || state == scc_pkg::ST_PTR || state == scc_pkg::ST_WR) begin
          shreg  <= {shreg[6:0], SDA_IN};
          bitcnt <= bitcnt + 4'h1;
        end
        if (state == scc_pkg::ST_ACK_RD) begin
          nack <= SDA_IN;
        end
      end else if (scl_fall) begin
        case (state)
          scc_pkg::ST_ADDR: begin
            if (bitcnt == 4'h8) begin
              rw    <= shreg[0];
              state <= (shreg[7:1] == scc_pkg::DEV_ADDR) ? scc_pkg::ST_ACK_ADDR : scc_pkg::ST_IDLE;
            end
          end
          scc_pkg::ST_ACK_ADDR: begin
            bitcnt <= 4'h0;
            tx     <= rd_now;
            state  <= rw ? scc_pkg::ST_RD : scc_pkg::ST_PTR;
          end
          scc_pkg::ST_PTR: begin
            if (bitcnt == 4'h8) begin
              ptr   <= shreg;
              state <= scc_pkg::ST_ACK_PTR;
            end
          end
          scc_pkg::ST_ACK_PTR: begin
            bitcnt <= 4'h0;
            state  <= scc_pkg::ST_WR;
          end
          scc_pkg::ST_WR: begin
            if (bitcnt == 4'h8) begin
              wr_data <= shreg;
              wr_stb  <= 1'b1;
              state   <= scc_pkg::ST_ACK_WR;
            end
          end
          scc_pkg::ST_ACK_WR: begin
            // pointer auto-increments so a burst fills consecutive registers
            ptr    <= ptr_inc;
            bitcnt <= 4'h0;
            state  <= scc_pkg::ST_WR;
          end
          scc_pkg::ST_RD: begin
            if (bitcnt == 4'h7) begin
              state <= scc_pkg::ST_ACK_RD;
            end else begin
              tx     <= {tx[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
          scc_pkg::ST_ACK_RD: begin
            if (nack) begin
              state <= scc_pkg::ST_IDLE;
            end else begin
              ptr    <= ptr_inc;
              tx     <= rd_inc;
              bitcnt <= 4'h0;
              state  <= scc_pkg::ST_RD;
            end
          end
          default: state <= scc_pkg::ST_IDLE;
        endcase
      end
    end
  end
  // open drain: only ever pull low
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = (state == scc_pkg::ST_ACK_ADDR) || (state == scc_pkg::ST_ACK_PTR) ||
                   (state == scc_pkg::ST_ACK_WR) || (state == scc_pkg::ST_RD && !tx[7]);
  // register storage; writes to unmapped pointers are dropped
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_ctrl   <= scc_pkg::RST_SYNC;
      cc_ctrl     <= scc_pkg::RST_CC;
      sog_ctrl    <= scc_pkg::RST_SOG;
      sep_thr     <= scc_pkg::RST_SEP;
      lead_lines  <= scc_pkg::RST_LEAD;
      trail_lines <= scc_pkg::RST_TRAIL;
    end else if (wr_stb) begin
      case (ptr)
        scc_pkg::ADDR_SYNC:  sync_ctrl   <= wr_data;
        scc_pkg::ADDR_CC:    cc_ctrl     <= {wr_data[7:1], 1'b0};
        scc_pkg::ADDR_SOG:   sog_ctrl    <= wr_data;
        scc_pkg::ADDR_SEP:   sep_thr     <= wr_data;
        scc_pkg::ADDR_LEAD:  lead_lines  <= wr_data;
        scc_pkg::ADDR_TRAIL: trail_lines <= wr_data;
        default:             sep_thr     <= sep_thr;
      endcase
    end
  end
  // polarity detectors for the hsync pin and the coast pin: the shorter level is the pulse
  logic [1:0] det_in;
  logic [1:0] det_pol;
  assign det_in = {COAST_IN, HSYNC_IN};
  generate
    for (genvar i = 0; i < 2; i++) begin : g_pol
      logic             prev;
      logic [scc_pkg::RUN_W-1:0] run;
      logic [scc_pkg::RUN_W-1:0] hi_len;
      logic [scc_pkg::RUN_W-1:0] lo_len;
      always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
          prev   <= 1'b0;
          run    <= '0;
          hi_len <= '0;
          lo_len <= '0;
        end else begin
          prev <= det_in[i];
          if (det_in[i] != prev) begin
            run <= '0;
            if (prev) begin
              hi_len <= run;
            end else begin
              lo_len <= run;
            end
          end else if (run != '1) begin
            run <= run + 1'b1;
          end
        end
      end
      assign det_pol[i] = hi_len < lo_len;
    end
  endgenerate
  // hsync source and polarity
  logic hs_pol_used;
  logic ahs_auto;
  logic hs_src_sog;
  logic hs_act;
  assign hs_pol_used = sync_ctrl.hs_pol_ovr ? sync_ctrl.hs_in_pol : det_pol[0];
  assign ahs_auto    = !HSYNC_PRESENT && SOG_PRESENT;
  assign hs_src_sog  = (sync_ctrl.ahs_ovr || (HSYNC_PRESENT && SOG_PRESENT)) ?
                       sync_ctrl.ahs_sel : ahs_auto;
  // sliced green sync is taken as negative-going
  assign hs_act      = hs_src_sog ? ~SOG_IN : ~(HSYNC_IN ^ hs_pol_used);
  // 5 MHz count enable for the sync separator
  logic [4:0] div_cnt;
  logic       sep_tick;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_cnt <= 5'h00;
    end else begin
      div_cnt <= (div_cnt == scc_pkg::SEP_DIV_LAST) ? 5'h00 : div_cnt + 5'h01;
    end
  end
  assign sep_tick = (div_cnt == scc_pkg::SEP_DIV_LAST);
  // separator: output follows the sync only after it has differed for thr+1 ticks
  logic [7:0] sep_cnt;
  logic       sep_vs;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sep_cnt <= 8'h00;
      sep_vs  <= 1'b0;
    end else if (hs_act == sep_vs) begin
      sep_cnt <= 8'h00;
    end else if (sep_tick) begin
      if (sep_cnt >= sep_thr) begin
        sep_vs  <= ~sep_vs;
        sep_cnt <= 8'h00;
      end else begin
        sep_cnt <= sep_cnt + 8'h01;
      end
    end
  end
  // vsync source
  logic avs_auto;
  logic vs_sel;
  assign avs_auto = !VSYNC_PRESENT;
  assign vs_sel   = (sync_ctrl.avs_ovr ? sync_ctrl.avs_sel : avs_auto) ? sep_vs : VSYNC_IN;
  // lead and trail coast window measured in hsync lines
  logic                       hs_d;
  logic                       vs_d;
  logic [scc_pkg::LINE_W-1:0] line_cnt;
  logic [scc_pkg::LINE_W-1:0] frame_len;
  logic [7:0]                 post_cnt;
  wire hs_edge = hs_act & ~hs_d;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      hs_d      <= 1'b0;
      vs_d      <= 1'b0;
      line_cnt  <= '0;
      frame_len <= '0;
      post_cnt  <= 8'h00;
    end else begin
      hs_d <= hs_act;
      vs_d <= vs_sel;
      if (vs_sel && !vs_d) begin
        frame_len <= line_cnt;
        line_cnt  <= '0;
      end else if (hs_edge && line_cnt != '1) begin
        line_cnt <= line_cnt + 1'b1;
      end
      if (!vs_sel && vs_d) begin
        post_cnt <= trail_lines;
      end else if (hs_edge && post_cnt != 8'h00) begin
        post_cnt <= post_cnt - 8'h01;
      end
    end
  end
  // lead start predicted from the previous frame length, so the first frame has none
  logic pre_act;
  logic vs_window;
  assign pre_act   = (lead_lines != 8'h00) && (frame_len > scc_pkg::LINE_W'(lead_lines)) &&
                     (line_cnt >= frame_len - scc_pkg::LINE_W'(lead_lines));
  // vs_d covers the cycle in which post_cnt loads, so coast shows no gap as vsync ends
  assign vs_window = vs_sel || (vs_d && trail_lines != 8'h00) || (post_cnt != 8'h00) || pre_act;
  // coast source and polarity
  logic coast_pol_used;
  logic coast_now;
  assign coast_pol_used = cc_ctrl.coast_pol_ovr ? cc_ctrl.coast_pol_high : det_pol[1];
  assign coast_now      = cc_ctrl.coast_from_vs ? vs_window : ~(COAST_IN ^ coast_pol_used);

  // registered outputs
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      PLL_HSYNC                  <= 1'b0;
      HSYNC_OUT                  <= 1'b0;
      VSYNC_OUT                  <= 1'b0;
      CLAMP                      <= 1'b0;
      COAST_ACTIVE               <= 1'b0;
      ACTIVE_HSYNC_SOURCE_STATUS <= 1'b0;
      ACTIVE_VSYNC_SOURCE_STATUS <= 1'b0;
      HSYNC_POL_DETECT           <= 1'b0;
      COAST_POL_DETECT           <= 1'b0;
    end else begin
      PLL_HSYNC                  <= hs_act & ~coast_now;
      HSYNC_OUT                  <= hs_act ^ sync_ctrl.hs_out_pol;
      VSYNC_OUT                  <= vs_sel ^ ~sync_ctrl.vs_out_keep;
      CLAMP                      <= cc_ctrl.clamp_ext ? (CLAMP_IN ^ cc_ctrl.clamp_pol_low) : hs_act;
      COAST_ACTIVE               <= coast_now;
      ACTIVE_HSYNC_SOURCE_STATUS <= ahs_auto;
      ACTIVE_VSYNC_SOURCE_STATUS <= avs_auto;
      HSYNC_POL_DETECT           <= det_pol[0];
      COAST_POL_DETECT           <= det_pol[1];
    end
  end

  assign SEEK_ALLOW        = cc_ctrl.seek_allow;
  assign FULL_POWER_DOWN_N = cc_ctrl.full_power_down_n;
  assign SOG_LEVEL         = sog_ctrl.sog_level;
  assign RED_CLAMP_MID     = sog_ctrl.red_mid;
  assign BLUE_CLAMP_MID    = sog_ctrl.blue_mid;

  // checks
  sequence s_cc_write_pd;
    wr_stb && ptr == scc_pkg::ADDR_CC && !wr_data[1];
  endsequence

  chk_coast_gates_pll: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    COAST_ACTIVE |-> !PLL_HSYNC) else $error("pll hsync passed during coast");
  chk_power_down_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    s_cc_write_pd |-> ##1 !FULL_POWER_DOWN_N) else $error("power-down write not applied");
  chk_unused_zero: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !cc_ctrl.unused) else $error("unused clamp/coast bit set");
  chk_tick_spacing: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    sep_tick |=> !sep_tick [*8]) else $error("separator tick too frequent");
  chk_sep_toggle: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    $changed(sep_vs) |-> $past(sep_tick) && $past(sep_cnt) >= $past(sep_thr)) else $error("early separator toggle");
  chk_hpol_override: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    sync_ctrl.hs_pol_ovr && !hs_src_sog |=> HSYNC_OUT == (($past(HSYNC_IN) ~^ $past(sync_ctrl.hs_in_pol)) ^
    $past(sync_ctrl.hs_out_pol))) else $error("hsync override polarity ignored");
  chk_post_load: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    $fell(vs_sel) |=> post_cnt == $past(trail_lines)) else $error("trail count not loaded");
  chk_coast_from_vs: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    cc_ctrl.coast_from_vs && vs_sel |=> COAST_ACTIVE) else $error("vsync coast missing");
  chk_vs_invert: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !sync_ctrl.vs_out_keep && $stable(sync_ctrl) |=> VSYNC_OUT == !$past(vs_sel)) else $error("vsync not inverted");

endmodule : scc_regs

/* File: core/scc_pkg.sv */
// constants, field layouts and states for the sync, clamp and coast control registers
// Overview of operation
// - hsync polarity override 0 uses detected polarity, 1 uses the hsync input polarity bit
// - hsync input polarity bit: 0 means active low, 1 means active high
// - hsync output polarity: 0 gives a high-going pulse, 1 a low-going pulse
// - active hsync override 1 uses the select bit, 0 follows detected source
// - hsync select: 0 dedicated pin, 1 sync-on-green; applies on override or both present
// - vsync output invert bit: 0 inverts the output, 1 passes it straight
// - active vsync override 1 uses the select bit, 0 follows detected source
// - vsync select: 0 raw vsync, 1 separator vsync; only under override
// - clamp function: 0 clamp timing from hsync, 1 from external clamp input
// - clamp polarity: 0 external clamp active high, 1 active low; internal unaffected
// - coast select: 0 coast from coast input, 1 coast from vsync
// - coast polarity override 0 uses detected polarity, 1 uses coast polarity bit
// - coast polarity bit: 0 active low, 1 active high; resets to 1
// - seek mode override 1 allows low-power mode, 0 forbids it
// - power-down bit active low: 0 powers down, 1 normal; resets to 1
// - red and blue clamp select: 0 ground, 1 midscale; both reset to 0
// - separator counts 5 MHz periods up to threshold before toggling its output
// - lead register: hsync periods before vsync that coast starts; resets to 0
// - trail register: hsync periods coast stays after vsync ends; resets to 0
// - coast blanks hsync toward the clock generator; coast input is asynchronous
// - status reports detected hsync source: 0 dedicated pin, 1 sync-on-green
package scc_pkg;

  localparam logic [7:0] ADDR_SYNC  = 8'h0E;
  localparam logic [7:0] ADDR_CC    = 8'h0F;
  localparam logic [7:0] ADDR_SOG   = 8'h10;
  localparam logic [7:0] ADDR_SEP   = 8'h11;
  localparam logic [7:0] ADDR_LEAD  = 8'h12;
  localparam logic [7:0] ADDR_TRAIL = 8'h13;

  localparam logic [7:0] RST_SYNC  = 8'h40;
  localparam logic [7:0] RST_CC    = 8'h4E;
  localparam logic [7:0] RST_SOG   = 8'h78;
  localparam logic [7:0] RST_SEP   = 8'h20;
  localparam logic [7:0] RST_LEAD  = 8'h00;
  localparam logic [7:0] RST_TRAIL = 8'h00;

  // serial slave address, value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h4C;

  localparam int CLK_HZ       = 125_000_000;
  localparam int SEP_TICK_HZ  = 5_000_000;
  localparam int SEP_DIV      = CLK_HZ / SEP_TICK_HZ;
  localparam logic [4:0] SEP_DIV_LAST = 5'(SEP_DIV - 1);

  localparam int RUN_W  = 16;
  localparam int LINE_W = 11;

  typedef struct packed {
    logic hs_pol_ovr;
    logic hs_in_pol;
    logic hs_out_pol;
    logic ahs_ovr;
    logic ahs_sel;
    logic vs_out_keep;
    logic avs_ovr;
    logic avs_sel;
  } scc_sync_ctrl_t;

  typedef struct packed {
    logic clamp_ext;
    logic clamp_pol_low;
    logic coast_from_vs;
    logic coast_pol_ovr;
    logic coast_pol_high;
    logic seek_allow;
    logic full_power_down_n;
    logic unused;
  } scc_cc_ctrl_t;

  typedef struct packed {
    logic [4:0] sog_level;
    logic       red_mid;
    logic       blue_mid;
    logic       sog_lsb;
  } scc_sog_ctrl_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR, ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } scc_ser_state_t;

endpackage : scc_pkg

/* File: tb/scc_ctl_model.sv */
// serial bus controller model that reads and writes the control registers
module scc_ctl_model (
  input  wire logic       clk,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_pull,
  output logic            rd_done,
  output logic [7:0]      rd_byte,
  output int              nack_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  // device samples scl without a filter, so each half period is kept at 5 clocks, above 4
  localparam int HALF = 5;
  localparam logic [6:0] ADDR = 7'h4C;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_done = 1'b0;
    rd_byte = 8'h00;
    nack_seen = 0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic start;
    sda_pull = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_pull = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask : start

  task automatic stop;
    sda_pull = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_pull = 1'b0;
    tick(HALF);
  endtask : stop

  // data changes only while scl is low and is held through the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    r = sda;
    scl = 1'b0;
  endtask : bit_io

  task automatic send(input logic [7:0] b, input logic want_ack, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
    if (want_ack && !ack) nack_seen++;
  endtask : send

  task automatic recv(input logic last);
    logic [7:0] b;
    logic       r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
    rd_byte = b;
    rd_done = 1'b1;
    tick(1);
    rd_done = 1'b0;
  endtask : recv

  task automatic wr(input logic [7:0] ptr, input int n, input logic [7:0] d0, input logic [7:0] d1);
    logic a;
    start();
    send({ADDR, 1'b0}, 1'b1, a);
    send(ptr, 1'b1, a);
    send(d0, 1'b1, a);
    if (n > 1) send(d1, 1'b1, a);
    stop();
  endtask : wr

  task automatic rd(input logic [7:0] ptr, input int n);
    logic a;
    start();
    send({ADDR, 1'b0}, 1'b1, a);
    send(ptr, 1'b1, a);
    start();
    send({ADDR, 1'b1}, 1'b1, a);
    for (int k = 0; k < n; k++) recv(k == n - 1);
    stop();
  endtask : rd

  task automatic probe(input logic [6:0] a7, output logic ack);
    start();
    send({a7, 1'b0}, 1'b0, ack);
    stop();
  endtask : probe
endmodule : scc_ctl_model

/* File: tb/tb_top.sv */
// self-checking bench for the sync, clamp and coast control registers
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock = 1'b0, reset_n = 1'b0;
  logic       hs_in, sog_in, vs_in, clamp_in, coast_in, hs_pres, sog_pres, vs_pres;
  logic       sda_out, sda_oe, pll_hs, hs_out, vs_out, clamp, coast_act, ahs_st, avs_st;
  logic       seek, pwr_n, red_mid, blue_mid, scl, sda_pull, rd_done, ack;
  logic [4:0] sog_lvl;
  logic [7:0] rd_byte, s, c, g, r;
  logic       active_hsync_source_status, act, co, hs_pol, co_pol;
  wire logic  sda;
  int         nack_seen, cycles = 0, fail_count = 0, samples_checked = 0;
  int         seed = 32'h7B6D2638;
  logic [7:0] exp_q[$];
  logic [7:0] rst_vals[7] = '{8'h40, 8'h4E, 8'h78, 8'h20, 8'h00, 8'h00, 8'h00};

  always #4 clock = ~clock;
  // open drain line with a pull-up: low if either party pulls
  assign sda = !(sda_oe || sda_pull);

  scc_regs dut (.CLOCK(clock), .RESET_N(reset_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .HSYNC_IN(hs_in), .SOG_IN(sog_in), .VSYNC_IN(vs_in), .CLAMP_IN(clamp_in),
    .COAST_IN(coast_in), .HSYNC_PRESENT(hs_pres), .SOG_PRESENT(sog_pres), .VSYNC_PRESENT(vs_pres),
    .PLL_HSYNC(pll_hs), .HSYNC_OUT(hs_out), .VSYNC_OUT(vs_out), .CLAMP(clamp), .COAST_ACTIVE(coast_act),
    .ACTIVE_HSYNC_SOURCE_STATUS(ahs_st), .ACTIVE_VSYNC_SOURCE_STATUS(avs_st), .HSYNC_POL_DETECT(hs_pol),
    .COAST_POL_DETECT(co_pol), .SEEK_ALLOW(seek), .FULL_POWER_DOWN_N(pwr_n), .SOG_LEVEL(sog_lvl),
    .RED_CLAMP_MID(red_mid), .BLUE_CLAMP_MID(blue_mid));

  scc_ctl_model ctl (.clk(clock), .sda(sda), .scl(scl), .sda_pull(sda_pull), .rd_done(rd_done),
    .rd_byte(rd_byte), .nack_seen(nack_seen));

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_byte

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // read results are matched against the oldest note as they come back
  always @(posedge clock) begin
    if (rd_done === 1'b1) begin
      if (exp_q.size() == 0) check_byte(rd_byte, 8'hXX, "unexpected read");
      else check_byte(rd_byte, exp_q.pop_front(), "read");
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      $display("FAIL %0t timeout", $time);
      test_done();
    end
  end

  initial begin
    {hs_in, sog_in, vs_in, clamp_in, coast_in, hs_pres, sog_pres, vs_pres} = 8'h46;
    repeat (8) @(posedge clock);
    #1 reset_n = 1'b1;
    tick(2);
    check_byte(seek, 1'b1, "seek reset");
    check_byte(pwr_n, 1'b1, "power reset");
    check_byte({sog_lvl, red_mid, blue_mid}, 7'h78 >> 1, "slicer reset");
    foreach (rst_vals[k]) exp_q.push_back(rst_vals[k]);
    ctl.rd(8'h0E, 7);
    ctl.probe(7'h4D, ack);
    check_byte(ack, 1'b0, "foreign address");
    for (int i = 0; i < 12; i++) begin
      s = 8'($random(seed));
      c = 8'($random(seed));
      r = 8'($random(seed));
      s[7] = 1'b1;
      s[6] = 1'b1;
      s[1] = 1'b1;
      s[0] = 1'b0;
      c[5] = 1'b0;
      c[4] = 1'b1;
      {hs_in, sog_in, vs_in, clamp_in, coast_in, hs_pres, sog_pres, vs_pres} = r;
      ctl.wr(8'h0E, 2, s, c);
      tick(4);
      active_hsync_source_status = (s[4] || (hs_pres && sog_pres)) ? s[3] : (!hs_pres && sog_pres);
      act = active_hsync_source_status ? !sog_in : hs_in;
      co = c[3] ? coast_in : !coast_in;
      check_byte(hs_out, act ^ s[5], "hsync out");
      check_byte(vs_out, s[2] ? vs_in : !vs_in, "vsync out");
      check_byte(coast_act, co, "coast");
      check_byte(pll_hs, co ? 1'b0 : act, "pll hsync");
      check_byte(clamp, c[7] ? clamp_in ^ c[6] : act, "clamp");
      check_byte({seek, pwr_n}, c[2:1], "power bits");
      check_byte(avs_st, !vs_pres, "vsync status");
      if (!(hs_pres && sog_pres)) check_byte(ahs_st, !hs_pres && sog_pres, "hsync status");
      exp_q.push_back(s);
      exp_q.push_back({c[7:1], 1'b0});
      ctl.rd(8'h0E, 2);
    end
    g = 8'($random(seed)) | 8'h01;
    ctl.wr(8'h10, 1, g, 8'h00);
    tick(3);
    check_byte({sog_lvl, red_mid, blue_mid}, g[7:1], "slicer");
    ctl.wr(8'h11, 2, 8'h30, 8'h00);
    ctl.wr(8'h13, 2, 8'h02, 8'h5A);
    exp_q.push_back(g);
    exp_q.push_back(8'h30);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h02);
    exp_q.push_back(8'h00);
    ctl.rd(8'h10, 5);
    // coast from vsync with a trail of two lines
    ctl.wr(8'h0E, 2, 8'hD2, 8'h22);
    {hs_in, vs_in} = 2'b11;
    tick(4);
    check_byte({coast_act, pll_hs}, 2'b10, "coast in vsync");
    {hs_in, vs_in} = 2'b00;
    tick(3);
    check_byte(coast_act, 1'b1, "coast trail");
    // short high pulses on both pins, so each detector should call its pin active high
    repeat (4) begin
      {hs_in, coast_in} = 2'b11;
      tick(10);
      {hs_in, coast_in} = 2'b00;
      tick(30);
    end
    check_byte(coast_act, 1'b0, "coast ended");
    {hs_in, coast_in} = 2'b11;
    tick(3);
    check_byte(pll_hs, 1'b1, "hsync passes");
    tick(20);
    // detected hsync polarity, separated vsync: hsync held active well past the separator threshold
    ctl.wr(8'h0E, 1, 8'h13, 8'h00);
    tick(1300);
    check_byte({hs_pol, co_pol}, 2'b11, "detected polarity");
    check_byte(hs_out, 1'b1, "auto hsync polarity");
    check_byte(vs_out, 1'b0, "separated vsync");
    check_byte(8'(nack_seen), 8'h00, "missing ack");
    check_byte(8'(exp_q.size()), 8'h00, "reads outstanding");
    test_done();
  end
endmodule : tb_top
